// *** design/asq_pkg.sv ***
// Shared constants and types for the analogue scan sequencer.
// Assumes a single 20 MHz clock; every user writes asq_pkg::name.
package asq_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int CONV_US = 100;
  localparam int CONV_CYC = CONV_US * (CLK_HZ / 1_000_000);
  localparam int SAR_BITS = 10;
  localparam int STEP_CYC = CONV_CYC / SAR_BITS;
  localparam int TMO_MS = 100;
  localparam int TMO_CYC = TMO_MS * (CLK_HZ / 1000);
  localparam logic [9:0] FULL_CODE = 10'h3E8;
  localparam logic [9:0] LOW_CODE = 10'h000;
  localparam logic [9:0] HIGH_CODE = 10'h3FC;
  localparam logic [2:0] LAST_CH = 3'h7;
  localparam logic [4:0] LAST_OFF = 5'h1F;
  localparam int FLG_MSB = 0;
  localparam int FLG_ZERO = 1;
  localparam int FLG_LOW = 2;
  localparam int FLG_HIGH = 3;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam int CTRL_RUN = 0;
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam int STAT_CH_LSB = 0;
  localparam int STAT_ST_LSB = 3;
  localparam int STAT_SEEN = 5;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_XFER = 2'b10
  } asq_state_t;

  typedef struct packed {
    logic high;
    logic low;
    logic msb;
    logic [3:0] hund;
    logic [3:0] tens;
    logic [3:0] units;
  } asq_result_t;
endpackage

// *** design/asq_sar.sv ***
// Successive-approximation search engine for one sample.
// Assumes the comparator input is already synchronised to mclk.
module asq_sar #(
  parameter int BITS = asq_pkg::SAR_BITS,
  parameter int STEP = asq_pkg::STEP_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic cmp_above,
  output logic [BITS-1:0] dac,
  output logic done,
  output logic [BITS-1:0] code
);
  localparam int CW = $clog2(STEP);
  localparam int BW = $clog2(BITS);

  logic [BITS-1:0] dac_q;
  logic [BITS-1:0] dac_d;
  logic [CW-1:0] cnt_q;
  logic [BW-1:0] bit_q;
  logic busy_q;
  logic done_q;
  logic step_end;

  assign step_end = busy_q && (cnt_q == CW'(STEP - 1));

  // Keep the trial bit when the input sits above the DAC
  always_comb
  begin
    dac_d = dac_q;
    if (!cmp_above)
      dac_d[bit_q] = 1'b0;
    if (bit_q != '0)
      dac_d[bit_q - BW'(1)] = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dac_q <= '0;
      cnt_q <= '0;
      bit_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (start)
    begin
      dac_q <= {1'b1, {(BITS-1){1'b0}}};
      bit_q <= BW'(BITS - 1);
      cnt_q <= '0;
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      cnt_q <= step_end ? '0 : (busy_q ? cnt_q + CW'(1) : '0);
      if (step_end)
      begin
        dac_q <= dac_d;
        // Stop at bit 0 so the trial index never wraps past the top
        if (bit_q == '0)
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        else
          bit_q <= bit_q - BW'(1);
      end
    end
  end

  assign dac = dac_q;
  assign done = done_q;
  assign code = dac_q;
endmodule // asq_sar

// *** design/asq_top.sv ***
// Scan sequencer: converts channels, buffers results, serves the
// processor scratchpad transfer, drives the panel display.
// Assumes external pins are asynchronous; Avalon master is on mclk.

module asq_top #(
  parameter int TMO_CYCLES = asq_pkg::TMO_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [10:0] processor_address,
  input wire logic address_valid_handshake,
  input wire logic [5:0] module_id,
  input wire logic [2:0] first_channel_select,
  input wire logic processor_reset_n,
  input wire logic [2:0] display_select,
  input wire logic comparator_above,
  output logic [9:0] sar_dac,
  output logic [2:0] mux_channel,
  output logic [3:0] processor_data_nibble,
  output logic preparation_done_o,
  output logic preparation_done_oe,
  output logic scratchpad_write_level_o,
  output logic scratchpad_write_level_oe,
  output logic [11:0] display_digits,
  output logic [2:0] display_points,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int SW = 27;

  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic [10:0] addr_s;
  logic avh_s;
  logic [5:0] mid_s;
  logic [2:0] first_s;
  logic prst_n_s;
  logic [2:0] dsel_s;
  logic cmp_s;
  logic seq_rst;

  asq_pkg::asq_state_t st_q;
  logic [2:0] ch_q;
  logic start_q;
  logic run_q;
  logic sar_done;
  logic [9:0] sar_code;
  asq_pkg::asq_result_t res_d;
  asq_pkg::asq_result_t buf_q [8];
  asq_pkg::asq_result_t cur;
  asq_pkg::asq_result_t disp_res;
  logic hit;
  logic [3:0] nib_d;
  logic [3:0] nib_q;
  logic prep_q;
  logic seen_q;
  logic last_q;
  logic [31:0] tmo_q;
  logic tmo_hit;
  logic [11:0] digits_q;
  logic [2:0] points_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [11:0] conv_age_q;

  // Two flops on every pin but mclk, rst and the Avalon slave port before use
  always_ff @(posedge mclk)
  begin
    sync1_q <= {processor_address, address_valid_handshake, module_id,
                first_channel_select, processor_reset_n, display_select,
                comparator_above, 1'b0};
    sync2_q <= sync1_q;
  end
  assign {addr_s, avh_s, mid_s, first_s, prst_n_s, dsel_s, cmp_s} = sync2_q[SW-1:1];
  assign seq_rst = rst || !prst_n_s;

  asq_sar u_sar (
    .mclk(mclk),
    .rst(seq_rst),
    .start(start_q),
    .cmp_above(cmp_s),
    .dac(sar_dac),
    .done(sar_done),
    .code(sar_code)
  );

  // Code is in units of 10 mV; clamp at full scale
  function automatic asq_pkg::asq_result_t to_bcd(input logic [9:0] c);
    asq_pkg::asq_result_t r;
    int n;
    n = (c > asq_pkg::FULL_CODE) ? int'(asq_pkg::FULL_CODE) : int'(c);
    r.high = (c > asq_pkg::HIGH_CODE);
    r.low = (c == asq_pkg::LOW_CODE);
    r.msb = (n >= 1000);
    r.hund = 4'((n / 100) % 10);
    r.tens = 4'((n / 10) % 10);
    r.units = 4'(n % 10);
    return r;
  endfunction
  assign res_d = to_bcd(sar_code);

  always_ff @(posedge mclk)
  begin
    if (rst)
      run_q <= asq_pkg::CTRL_RUN_RST;
    else if (avs_write && ack_q && avs_address == asq_pkg::REG_CTRL)
      run_q <= avs_writedata[asq_pkg::CTRL_RUN];
  end

  // Sequencer
  always_ff @(posedge mclk)
  begin
    if (seq_rst)
    begin
      st_q <= asq_pkg::ST_IDLE;
      ch_q <= 3'h0;
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= 1'b0;
      case (st_q)
        asq_pkg::ST_IDLE:
          if (run_q)
          begin
            ch_q <= first_s;
            start_q <= 1'b1;
            st_q <= asq_pkg::ST_CONV;
          end
        asq_pkg::ST_CONV:
          if (sar_done)
          begin
            if (ch_q == asq_pkg::LAST_CH)
              st_q <= asq_pkg::ST_XFER;
            else
            begin
              ch_q <= ch_q + 3'h1;
              start_q <= 1'b1;
            end
          end
        asq_pkg::ST_XFER:
          if ((last_q && !avh_s) || tmo_hit)
            st_q <= asq_pkg::ST_IDLE;
        default:
          st_q <= asq_pkg::ST_IDLE;
      endcase
    end
  end
  assign mux_channel = ch_q;

  // Cleared so panel and transfer never show unknowns before a scan
  always_ff @(posedge mclk)
  begin
    if (rst)
      buf_q <= '{default: '0};
    else if (st_q == asq_pkg::ST_CONV && sar_done)
      buf_q[ch_q] <= res_d;
  end

  // Only in the transfer phase, own block, offsets from 4*first
  assign hit = (st_q == asq_pkg::ST_XFER) && avh_s
               && (addr_s[10:5] == mid_s)
               && (addr_s[4:2] >= first_s);
  assign cur = buf_q[addr_s[4:2]];

  always_comb
  begin
    case (addr_s[1:0])
      2'h0:
      begin
        nib_d = 4'h0;
        nib_d[asq_pkg::FLG_MSB] = cur.msb;
        nib_d[asq_pkg::FLG_LOW] = cur.low;
        nib_d[asq_pkg::FLG_HIGH] = cur.high;
      end
      2'h1: nib_d = cur.hund;
      2'h2: nib_d = cur.tens;
      default: nib_d = cur.units;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (seq_rst)
    begin
      nib_q <= 4'h0;
      prep_q <= 1'b0;
    end
    else
    begin
      nib_q <= hit ? nib_d : 4'h0;
      prep_q <= hit;
    end
  end
  assign processor_data_nibble = nib_q;
  // Open collector: enable pulls the line low
  assign preparation_done_o = 1'b0;
  assign preparation_done_oe = prep_q;
  assign scratchpad_write_level_o = 1'b0;
  assign scratchpad_write_level_oe = prep_q;

  // Transfer progress and the no-transfer watchdog
  always_ff @(posedge mclk)
  begin
    if (seq_rst || st_q != asq_pkg::ST_XFER)
    begin
      seen_q <= 1'b0;
      last_q <= 1'b0;
    end
    else if (hit)
    begin
      seen_q <= 1'b1;
      if (addr_s[4:0] == asq_pkg::LAST_OFF)
        last_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (seq_rst || st_q != asq_pkg::ST_XFER || seen_q)
      tmo_q <= 32'h0;
    else
      tmo_q <= tmo_q + 32'h1;
  end
  assign tmo_hit = !seen_q && (tmo_q == 32'(TMO_CYCLES - 1));

  // Panel display follows the thumbwheel channel
  assign disp_res = buf_q[dsel_s];
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      digits_q <= 12'h000;
      points_q <= 3'h0;
    end
    else
    begin
      digits_q <= {disp_res.hund, disp_res.tens, disp_res.units};
      points_q <= {3{disp_res.msb}};
    end
  end
  assign display_digits = digits_q;
  assign display_points = points_q;

  // Avalon slave: fixed one wait state, unmapped reads give zero
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end
    else
    begin
      ack_q <= (avs_read || avs_write) && !ack_q;
      if (avs_read && !ack_q)
        case (avs_address)
          asq_pkg::REG_CTRL: rdata_q <= {31'h0, run_q};
          asq_pkg::REG_STAT: rdata_q <= {26'h0, seen_q, st_q, ch_q};
          default: rdata_q <= 32'h0;
        endcase
    end
  end
  assign avs_waitrequest = !ack_q;
  assign avs_readdata = rdata_q;

  // Checking helper: cycles since conversion start
  always_ff @(posedge mclk)
  begin
    if (seq_rst || start_q)
      conv_age_q <= 12'h000;
    else
      conv_age_q <= conv_age_q + 12'h001;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (seq_rst);

  a_full_clamp: assert property (
    sar_done && sar_code >= asq_pkg::FULL_CODE |-> res_d.msb && res_d.hund == 4'h0
    && res_d.tens == 4'h0 && res_d.units == 4'h0)
    else $error("full scale not clamped to 1000");
  a_msb_bit: assert property (
    sar_done && sar_code < asq_pkg::FULL_CODE |-> !res_d.msb)
    else $error("extra bit set below full scale");
  a_flag_nibble: assert property (
    hit && addr_s[1:0] == 2'h0 |=> !nib_q[asq_pkg::FLG_ZERO]
    && nib_q[asq_pkg::FLG_HIGH] == $past(cur.high))
    else $error("flag nibble wrong");
  a_first_chan: assert property (
    st_q == asq_pkg::ST_IDLE && run_q |=> st_q == asq_pkg::ST_CONV
    && ch_q == $past(first_s))
    else $error("scan did not start at selected channel");
  a_range_block: assert property (
    avh_s && addr_s[4:2] < first_s |=> !preparation_done_oe)
    else $error("answered below first offset");
  a_id_match: assert property (
    preparation_done_oe |-> $past(addr_s[10:5] == mid_s) && $past(avh_s))
    else $error("answered foreign block");
  a_chan_order: assert property (
    st_q == asq_pkg::ST_CONV && sar_done && ch_q != asq_pkg::LAST_CH
    |=> ch_q == $past(ch_q) + 3'h1 && start_q)
    else $error("channel order broken");
  a_to_xfer: assert property (
    st_q == asq_pkg::ST_CONV && sar_done && ch_q == asq_pkg::LAST_CH
    |=> st_q == asq_pkg::ST_XFER)
    else $error("no transfer after last channel");
  a_rescan: assert property (
    st_q == asq_pkg::ST_XFER && last_q && !avh_s && run_q
    |=> st_q == asq_pkg::ST_IDLE ##1 start_q)
    else $error("no rescan after transfer");
  a_conv_time: assert property (
    sar_done |-> conv_age_q == 12'(asq_pkg::CONV_CYC))
    else $error("conversion time wrong");
  a_timeout: assert property (
    tmo_hit |-> tmo_q == 32'(TMO_CYCLES - 1) ##1 st_q == asq_pkg::ST_IDLE)
    else $error("timeout restart missing");
  a_both_levels: assert property (
    preparation_done_oe == scratchpad_write_level_oe)
    else $error("handshake outputs disagree");
  a_points: assert property (
    ##1 display_points == {3{$past(disp_res.msb)}})
    else $error("decimal points wrong");
  a_data_quiet: assert property (
    !hit |=> processor_data_nibble == 4'h0 && !preparation_done_oe)
    else $error("data driven while not addressed");
  a_proc_reset: assert property (@(posedge mclk) disable iff (rst)
    !prst_n_s |=> st_q == asq_pkg::ST_IDLE && !preparation_done_oe)
    else $error("processor reset ignored");

  c_full_xfer: cover property (st_q == asq_pkg::ST_XFER && last_q && !avh_s);
  c_timeout: cover property (tmo_hit);
  c_over_disp: cover property (display_points == 3'h7);
endmodule // asq_top

// *** tb/asq_cpu_model.sv ***
// Processor partner: backplane address cycles and the analogue comparator.
// Assumes codes hold each channel's input level as a converter code.
module asq_cpu_model (
  input wire logic mclk,
  input wire logic [79:0] codes,
  input wire logic [2:0] mux_channel,
  input wire logic [9:0] sar_dac,
  output logic comparator_above,
  input wire logic req,
  input wire logic [10:0] req_addr,
  output logic ack,
  output logic hit,
  output logic [3:0] rdata,
  output logic [10:0] processor_address,
  output logic address_valid_handshake,
  input wire logic prep_oe,
  input wire logic [3:0] nibble
);
  timeunit 1ns;
  timeprecision 100ps;
  int n;
  assign comparator_above = codes[mux_channel * 10 +: 10] >= sar_dac;
  initial
  begin
    ack = 1'b0;
    hit = 1'b0;
    rdata = 4'h0;
    processor_address = 11'h000;
    address_valid_handshake = 1'b0;
    forever
    begin
      @(posedge mclk);
      ack <= 1'b0;
      if (req === 1'b1 && ack === 1'b0)
      begin
        processor_address <= req_addr;
        @(posedge mclk);
        // Valid only after the address has settled a full cycle
        address_valid_handshake <= 1'b1;
        for (n = 0; n < 10 && prep_oe !== 1'b1; n++)
          @(posedge mclk);
        hit <= (prep_oe === 1'b1);
        rdata <= nibble;
        address_valid_handshake <= 1'b0;
        // Released lines show no stale address
        processor_address <= ~req_addr;
        for (n = 0; n < 10 && prep_oe !== 1'b0; n++)
          @(posedge mclk);
        ack <= 1'b1;
      end
    end
  end
endmodule // asq_cpu_model

// *** tb/analog_scan_sequencer_test.sv ***
// Self-checking bench: registers, scan, transfer, timeout and processor reset.
// Assumes asq_top with a short timeout and the asq_cpu_model partner.
module analog_scan_sequencer_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TMO = 500;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic prst_n = 1'b1;
  logic [5:0] mid;
  logic [2:0] k;
  logic [2:0] dsel = 3'h0;
  logic [79:0] codes;
  logic req = 1'b0;
  logic [10:0] req_addr = 11'h000;
  logic ack, hit, cmp, avh, prep_oe, wl_oe, prep_o, wl_o;
  logic [3:0] rdata, nib;
  logic [10:0] paddr;
  logic [9:0] dac;
  logic [2:0] mux, pts;
  logic [11:0] digs;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  int failures = 0;
  int checks = 0;

  always #25 mclk = ~mclk;

  asq_top #(.TMO_CYCLES(TMO)) i_asq_top (
    .mclk(mclk), .rst(rst), .processor_address(paddr), .address_valid_handshake(avh),
    .module_id(mid), .first_channel_select(k), .processor_reset_n(prst_n),
    .display_select(dsel), .comparator_above(cmp), .sar_dac(dac), .mux_channel(mux),
    .processor_data_nibble(nib), .preparation_done_o(prep_o), .preparation_done_oe(prep_oe),
    .scratchpad_write_level_o(wl_o), .scratchpad_write_level_oe(wl_oe),
    .display_digits(digs), .display_points(pts), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  asq_cpu_model i_asq_cpu_model (
    .mclk(mclk), .codes(codes), .mux_channel(mux), .sar_dac(dac), .comparator_above(cmp),
    .req(req), .req_addr(req_addr), .ack(ack), .hit(hit), .rdata(rdata),
    .processor_address(paddr), .address_valid_handshake(avh), .prep_oe(prep_oe),
    .nibble(nib));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want)
    begin
      failures++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [3:0] exp_nib(input logic [9:0] c, input int dg);
    int v;
    v = (c > asq_pkg::FULL_CODE) ? 1000 : int'(c);
    case (dg)
      0: return {c > asq_pkg::HIGH_CODE, c == 10'h000, 1'b0, v == 1000};
      1: return 4'(v / 100 % 10);
      2: return 4'(v / 10 % 10);
      default: return 4'(v % 10);
    endcase
  endfunction

  // Answer taken at the rising edge that sees waitrequest low; only the watchdog ends a hang
  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                         output logic [31:0] rd);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wait_stat(input logic [5:0] mask, input logic [5:0] val, input int lim,
                           output logic [31:0] s);
    for (int n = 0; n < lim; n++)
    begin
      av_xfer(1'b0, asq_pkg::REG_STAT, 32'h0, s);
      if ((s[5:0] & mask) === val)
        break;
    end
  endtask

  task automatic sp_read(input logic [10:0] a, output logic h, output logic [3:0] d);
    @(posedge mclk);
    req_addr <= a;
    req <= 1'b1;
    @(posedge mclk);
    while (ack !== 1'b1)
      @(posedge mclk);
    h = hit;
    d = rdata;
    req <= 1'b0;
  endtask

  task automatic serve(input int first);
    logic h;
    logic [3:0] d;
    for (int off = 4 * first; off < 32; off++)
    begin
      sp_read({mid, 5'(off)}, h, d);
      check(h, 1'b1);
      check(d, exp_nib(codes[off / 4 * 10 +: 10], off % 4));
    end
  endtask

  always @(negedge mclk)
    if (prep_oe === 1'b1)
    begin
      check(wl_oe, 1'b1);
      check({prep_o, wl_o}, 2'h0);
    end

  always @(negedge mclk)
    if (rst === 1'b0 && prep_oe === 1'b0)
      check(nib, 4'h0);

  initial
  begin
    logic [31:0] s;
    logic h;
    logic [3:0] d;
    int n;
    void'($urandom(15));
    k <= 3'($urandom % 5);
    mid <= 6'($urandom);
    for (int c = 0; c < 8; c++)
      codes[c * 10 +: 10] = 10'($urandom % 1024);
    // Corners: 999, zero, full scale, above the high limit
    codes[79:40] = {10'h3FD, 10'h3E8, 10'h000, 10'h3E7};
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    wait_stat(6'h1F, {3'h1, k}, 10, s);
    check(s[4:0], {2'h1, k});
    av_xfer(1'b0, asq_pkg::REG_CTRL, 32'h0, s);
    check(s[asq_pkg::CTRL_RUN], asq_pkg::CTRL_RUN_RST);
    av_xfer(1'b1, 4'hC, 32'hFFFFFFFF, s);
    av_xfer(1'b0, 4'hC, 32'h0, s);
    check(s, 32'h0);
    // Run bit cleared and restored while a conversion is under way
    av_xfer(1'b1, asq_pkg::REG_CTRL, 32'h0, s);
    av_xfer(1'b0, asq_pkg::REG_CTRL, 32'h0, s);
    check(s, 32'h0);
    av_xfer(1'b1, asq_pkg::REG_CTRL, 32'h1, s);
    av_xfer(1'b0, asq_pkg::REG_CTRL, 32'h0, s);
    check(s, 32'h1);
    $display("test registers done");
    for (n = 0; n < 3000 && mux === k; n++)
      @(negedge mclk);
    for (n = 0; n < 3000 && mux === k + 3'h1; n++)
      @(negedge mclk);
    check(n >= 1999 && n <= 2010, 1'b1);
    wait_stat(6'h18, 6'h10, 8000, s);
    check(s[4:0], 5'h17);
    sp_read({~mid, 5'h00}, h, d);
    check(h, 1'b0);
    if (k != 3'h0)
    begin
      sp_read({mid, 5'(4 * k) - 5'h01}, h, d);
      check(h, 1'b0);
    end
    serve(k);
    wait_stat(6'h1F, {3'h1, k}, 20, s);
    check(s[4:0], {2'h1, k});
    for (int c = k; c < 8; c++)
    begin
      @(posedge mclk);
      dsel <= 3'(c);
      repeat (8) @(negedge mclk);
      check(digs, {exp_nib(codes[c * 10 +: 10], 1), exp_nib(codes[c * 10 +: 10], 2),
                   exp_nib(codes[c * 10 +: 10], 3)});
      check(pts, codes[c * 10 +: 10] >= asq_pkg::FULL_CODE ? 3'h7 : 3'h0);
    end
    $display("test scan and transfer done");
    @(posedge mclk);
    k <= 3'h7;
    prst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    prst_n <= 1'b1;
    wait_stat(6'h1F, 6'h0F, 20, s);
    check(s[4:0], 5'h0F);
    check(mux, 3'h7);
    wait_stat(6'h18, 6'h10, 1000, s);
    check(s[4:3], 2'h2);
    repeat (TMO - 60) @(posedge mclk);
    av_xfer(1'b0, asq_pkg::REG_STAT, 32'h0, s);
    check(s[4:3], 2'h2);
    wait_stat(6'h18, 6'h08, 100, s);
    check(s[4:3], 2'h1);
    wait_stat(6'h18, 6'h10, 1000, s);
    sp_read({mid, 5'h18}, h, d);
    check(h, 1'b0);
    serve(7);
    $display("test reset and timeout done");
    summarize();
  end

  initial
  begin
    repeat (60000) @(posedge mclk);
    failures++;
    summarize();
  end
endmodule // analog_scan_sequencer_test
